// ### hdl/cmpc_cfg.svh
// Register offsets, field positions and reset values of the comparator control block.
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH
`define CMPC_OFS_CTRL_B 12'h000
`define CMPC_OFS_CSR 12'h004
`define CMPC_OFS_DIDR 12'h008
`define CMPC_OFS_MUXSEL 12'h00C
`define CMPC_OFS_CONVA 12'h010
`define CMPC_OFS_IRQ_STAT 12'h014
`define CMPC_OFS_IRQ_MASK 12'h018
`define CMPC_BIT_MUX_EN 6
`define CMPC_BIT_PWR_OFF 7
`define CMPC_BIT_BANDGAP 6
`define CMPC_BIT_RESULT 5
`define CMPC_BIT_FLAG 4
`define CMPC_BIT_IRQ_EN 3
`define CMPC_BIT_CAPTURE 2
`define CMPC_BIT_MODE_HI 1
`define CMPC_BIT_MODE_LO 0
`define CMPC_BIT_NEG_OFF 1
`define CMPC_BIT_POS_OFF 0
`define CMPC_BIT_CONV_EN 7
`define CMPC_RST_BYTE 8'h00
`define CMPC_RST_MODE 2'h0
`endif

// ### hdl/cmpc_comparator_control.sv
// Comparator control and status logic with an APB register slave.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "cmpc_cfg.svh"

// What this block does
// - Result bit is high when selected positive input exceeds selected negative input.
// - Raw comparator output is synchronised, giving one to two cycles latency.
// - Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Interrupt flag in bit 4 sets on a transition matching the mode.
// - Flag clears when the processor takes the comparator vector.
// - Writing one clears the flag; writing zero leaves it.
// - Interrupt requested only with flag, enable bit 3 and global enable set.
// - Disable bit 7 switches the comparator off, settable any time.
// - Bandgap select bit 6 picks the internal reference as positive input.
// - Capture enable bit 2 routes the result to the timer capture front end.
// - Mux enable with converter off selects channel 0..7 as negative input.
// - Pin buffer-off bits disable the buffer and read the pin bit as zero.
// - Converter enable bit marks the converter on; zero lends the mux.
module cmpc_comparator_control (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator and its input selection.
  input wire logic comparator_raw,
  output logic comparator_power_off,
  output logic bandgap_positive_select,
  output logic negative_from_mux,
  output cmpc_pkg::cmpc_chan_t negative_channel,
  // Pin digital input buffers.
  input wire logic cmp_positive_pin_in,
  input wire logic cmp_negative_pin_in,
  output logic positive_pin_buffer_off,
  output logic negative_pin_buffer_off,
  output logic cmp_positive_pin_read,
  output logic cmp_negative_pin_read,
  // Processor interrupt interface.
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic comparator_irq_req,
  // Timer capture front end.
  output logic capture_route_enable,
  output logic capture_input,
  // Summary interrupt line.
  output logic irq
);
  import cmpc_pkg::*;

  cmpc_byte_t csr_q, csr_d;
  logic mux_en_q, mux_en_d;
  logic conv_en_q, conv_en_d;
  cmpc_chan_t chan_q, chan_d;
  logic pos_off_q, pos_off_d, neg_off_q, neg_off_d;
  logic sync1_q, sync1_d, sync2_q, sync2_d, prev_q, prev_d;
  logic stat_q, stat_d, mask_q, mask_d;
  logic wr, rd, mapped, rise, fall, event_hit;
  logic [31:0] rdata_d;

  // Bus strobes; the slave answers in the first access cycle.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `CMPC_OFS_CTRL_B) || (paddr == `CMPC_OFS_CSR) ||
                  (paddr == `CMPC_OFS_DIDR) || (paddr == `CMPC_OFS_MUXSEL) ||
                  (paddr == `CMPC_OFS_CONVA) || (paddr == `CMPC_OFS_IRQ_STAT) ||
                  (paddr == `CMPC_OFS_IRQ_MASK);
  assign pslverr = psel && penable && !mapped;

  // Edge detection on the synchronised result, per the selected mode.
  assign rise = sync2_q && !prev_q;
  assign fall = !sync2_q && prev_q;
  always_comb begin
    unique case (cmpc_mode_e'(csr_q[`CMPC_BIT_MODE_HI:`CMPC_BIT_MODE_LO]))
      CMPC_MODE_TOGGLE: event_hit = rise || fall;
      CMPC_MODE_FALL: event_hit = fall;
      CMPC_MODE_RISE: event_hit = rise;
      CMPC_MODE_RSVD: event_hit = 1'b0;
    endcase
  end

  // Synchroniser; frozen while powered off so no edge can appear.
  always_comb begin
    sync1_d = sync1_q;
    sync2_d = sync2_q;
    prev_d = prev_q;
    if (!csr_q[`CMPC_BIT_PWR_OFF]) begin
      sync1_d = comparator_raw;
      sync2_d = sync1_q;
      prev_d = sync2_q;
    end
  end

  // Register file next state; hardware set beats software clear.
  always_comb begin
    csr_d = csr_q;
    mux_en_d = mux_en_q;
    conv_en_d = conv_en_q;
    chan_d = chan_q;
    pos_off_d = pos_off_q;
    neg_off_d = neg_off_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr) begin
      unique case (paddr)
        `CMPC_OFS_CTRL_B: mux_en_d = pwdata[`CMPC_BIT_MUX_EN];
        `CMPC_OFS_CSR: begin
          csr_d[`CMPC_BIT_PWR_OFF] = pwdata[`CMPC_BIT_PWR_OFF];
          csr_d[`CMPC_BIT_BANDGAP] = pwdata[`CMPC_BIT_BANDGAP];
          csr_d[`CMPC_BIT_IRQ_EN:`CMPC_BIT_MODE_LO] = pwdata[`CMPC_BIT_IRQ_EN:`CMPC_BIT_MODE_LO];
          if (pwdata[`CMPC_BIT_FLAG]) begin
            csr_d[`CMPC_BIT_FLAG] = 1'b0;
          end
        end
        `CMPC_OFS_DIDR: begin
          pos_off_d = pwdata[`CMPC_BIT_POS_OFF];
          neg_off_d = pwdata[`CMPC_BIT_NEG_OFF];
        end
        `CMPC_OFS_MUXSEL: chan_d = pwdata[2:0];
        `CMPC_OFS_CONVA: conv_en_d = pwdata[`CMPC_BIT_CONV_EN];
        `CMPC_OFS_IRQ_STAT: begin
          if (pwdata[0]) begin
            stat_d = 1'b0;
          end
        end
        `CMPC_OFS_IRQ_MASK: mask_d = pwdata[0];
        default: begin
        end
      endcase
    end
    if (irq_vector_taken) begin
      csr_d[`CMPC_BIT_FLAG] = 1'b0;
    end
    csr_d[`CMPC_BIT_RESULT] = 1'b0;
    if (event_hit && !csr_q[`CMPC_BIT_PWR_OFF]) begin
      csr_d[`CMPC_BIT_FLAG] = 1'b1;
      stat_d = 1'b1;
    end
  end

  // Read data is registered in the setup cycle, valid in the access cycle.
  always_comb begin
    rdata_d = prdata;
    if (rd) begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        `CMPC_OFS_CTRL_B: rdata_d[`CMPC_BIT_MUX_EN] = mux_en_q;
        `CMPC_OFS_CSR: begin
          rdata_d[7:0] = csr_q;
          rdata_d[`CMPC_BIT_RESULT] = sync2_q;
        end
        `CMPC_OFS_DIDR: begin
          rdata_d[`CMPC_BIT_POS_OFF] = pos_off_q;
          rdata_d[`CMPC_BIT_NEG_OFF] = neg_off_q;
        end
        `CMPC_OFS_MUXSEL: rdata_d[2:0] = chan_q;
        `CMPC_OFS_CONVA: rdata_d[`CMPC_BIT_CONV_EN] = conv_en_q;
        `CMPC_OFS_IRQ_STAT: rdata_d[0] = stat_q;
        `CMPC_OFS_IRQ_MASK: rdata_d[0] = mask_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // All state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_q <= `CMPC_RST_BYTE;
      mux_en_q <= 1'b0;
      conv_en_q <= 1'b0;
      chan_q <= 3'h0;
      pos_off_q <= 1'b0;
      neg_off_q <= 1'b0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      csr_q <= csr_d;
      mux_en_q <= mux_en_d;
      conv_en_q <= conv_en_d;
      chan_q <= chan_d;
      pos_off_q <= pos_off_d;
      neg_off_q <= neg_off_d;
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      prdata <= rdata_d;
    end
  end

  // Analog side controls and input routing.
  assign comparator_power_off = csr_q[`CMPC_BIT_PWR_OFF];
  assign bandgap_positive_select = csr_q[`CMPC_BIT_BANDGAP];
  assign negative_from_mux = mux_en_q && !conv_en_q;
  assign negative_channel = chan_q;
  // Pin buffers; a disabled buffer reads as zero.
  assign positive_pin_buffer_off = pos_off_q;
  assign negative_pin_buffer_off = neg_off_q;
  assign cmp_positive_pin_read = cmp_positive_pin_in && !pos_off_q;
  assign cmp_negative_pin_read = cmp_negative_pin_in && !neg_off_q;
  // Processor interrupt request needs flag, local and global enable.
  assign comparator_irq_req = csr_q[`CMPC_BIT_FLAG] && csr_q[`CMPC_BIT_IRQ_EN] &&
                              global_irq_enable;
  // Capture route; held low while disabled so no trigger leaks out.
  assign capture_route_enable = csr_q[`CMPC_BIT_CAPTURE];
  assign capture_input = csr_q[`CMPC_BIT_CAPTURE] && sync2_q &&
                         !csr_q[`CMPC_BIT_PWR_OFF];
  assign irq = stat_q && mask_q;
endmodule

// ### hdl/cmpc_pkg.sv
// Types shared by the comparator control block.
package cmpc_pkg;
  typedef logic [1:0] cmpc_mode_t;
  typedef logic [2:0] cmpc_chan_t;
  typedef logic [7:0] cmpc_byte_t;
  typedef enum logic [1:0] {
    CMPC_MODE_TOGGLE = 2'b00,
    CMPC_MODE_RSVD = 2'b01,
    CMPC_MODE_FALL = 2'b10,
    CMPC_MODE_RISE = 2'b11
  } cmpc_mode_e;
endpackage

// ### testbench/cmpc_analog_model.sv
// Behavioural analog comparator answering the block's input selections.
`timescale 1ns/1ps
module cmpc_analog_model #(
  parameter logic [7:0] BANDGAP_LEVEL = 8'h40
) (
  // Selections from the block, pin levels as codes, raw result.
  input logic comparator_power_off, bandgap_positive_select, negative_from_mux,
  input cmpc_pkg::cmpc_chan_t negative_channel,
  input logic [7:0] pos_v, neg_v,
  output logic comparator_raw
);
  logic [7:0] p;
  logic [7:0] n;
  // Each channel sits at its own level, so a wrong channel shows in the result.
  always_comb begin
    p = bandgap_positive_select ? BANDGAP_LEVEL : pos_v;
    n = negative_from_mux ? {negative_channel, 5'h10} : neg_v;
    comparator_raw = comparator_power_off ? 1'b0 : (p > n);
  end
endmodule

// ### testbench/cmpc_monitor.sv
// Port checker for the comparator control block.
`timescale 1ns/1ps
module cmpc_monitor (
  // Clock, reset, comparator, interrupt and pin signals.
  input logic pclk, presetn, comparator_raw, comparator_power_off, capture_route_enable,
  input logic capture_input, global_irq_enable, comparator_irq_req, irq,
  input logic cmp_positive_pin_in, cmp_negative_pin_in, positive_pin_buffer_off,
  input logic negative_pin_buffer_off, cmp_positive_pin_read, cmp_negative_pin_read
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The capture input shows the synchronised result only while routed and powered.
  logic live;
  assign live = capture_route_enable && !comparator_power_off;
  route_gate_a: assert property (!capture_route_enable |-> !capture_input)
    else $error("capture without route");
  power_gate_a: assert property (comparator_power_off |-> !capture_input)
    else $error("capture while off");
  sync_high_a: assert property ((live && comparator_raw)[*3] |-> capture_input)
    else $error("result late high");
  sync_low_a: assert property ((live && !comparator_raw)[*3] |-> !capture_input)
    else $error("result late low");
  sync_min_a: assert property ((live && !comparator_raw)[*2] ##1 comparator_raw
    |-> !capture_input ##1 !capture_input) else $error("result early");
  irq_gate_a: assert property (!global_irq_enable |-> !comparator_irq_req)
    else $error("request without global enable");
  pos_read_a: assert property (cmp_positive_pin_read ==
    (cmp_positive_pin_in && !positive_pin_buffer_off)) else $error("positive pin read");
  neg_read_a: assert property (cmp_negative_pin_read ==
    (cmp_negative_pin_in && !negative_pin_buffer_off)) else $error("negative pin read");
  cover property ($rose(capture_input));
  cover property ($rose(comparator_irq_req));
  cover property ($rose(irq));
  cover property ($rose(comparator_power_off));
endmodule
bind cmpc_comparator_control cmpc_monitor i_cmpc_monitor (.pclk, .presetn, .comparator_raw,
  .comparator_power_off, .capture_route_enable, .capture_input, .global_irq_enable,
  .comparator_irq_req, .irq, .cmp_positive_pin_in, .cmp_negative_pin_in,
  .positive_pin_buffer_off, .negative_pin_buffer_off, .cmp_positive_pin_read,
  .cmp_negative_pin_read);

// ### testbench/testbench.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
`include "cmpc_cfg.svh"
module testbench;
  import cmpc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cmp_positive_pin_in = 1'b0, cmp_negative_pin_in = 1'b0;
  logic global_irq_enable = 1'b0, irq_vector_taken = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic rerr;
  logic [7:0] pos_v = 8'h10, neg_v = 8'h80;
  logic pready, pslverr, comparator_raw, comparator_power_off, bandgap_positive_select;
  logic negative_from_mux, positive_pin_buffer_off, negative_pin_buffer_off, irq;
  logic cmp_positive_pin_read, cmp_negative_pin_read, comparator_irq_req;
  logic capture_route_enable, capture_input;
  cmpc_chan_t negative_channel;
  int err_total = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  cmpc_comparator_control i_cmpc_comparator_control (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .comparator_raw, .comparator_power_off,
    .bandgap_positive_select, .negative_from_mux, .negative_channel, .cmp_positive_pin_in,
    .cmp_negative_pin_in, .positive_pin_buffer_off, .negative_pin_buffer_off,
    .cmp_positive_pin_read, .cmp_negative_pin_read, .global_irq_enable, .irq_vector_taken,
    .comparator_irq_req, .capture_route_enable, .capture_input, .irq);
  cmpc_analog_model i_cmpc_analog_model (.comparator_power_off, .bandgap_positive_select,
    .negative_from_mux, .negative_channel, .pos_v, .neg_v, .comparator_raw);
  task end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One transfer; the access phase is held until pready, bounded so a hang ends the run.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim;
    end
    rv = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rv, e);
  endtask
  // Let the result cross the synchroniser and edge logic, then sample between edges.
  task settle;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask
  task t_reset;
    for (int a = 0; a < 32; a += 4) begin
      rd(12'(a), 32'h0);
      chk(32'(rerr), 32'(a == 28));
      chk(32'(pready), 32'h1);
    end
  endtask
  task t_modes;
    for (int i = 0; i < 4; i++) begin
      apb(`CMPC_OFS_CSR, 1'b1, 32'(i + 16));
      pos_v <= 8'hF0;
      settle;
      apb(`CMPC_OFS_CSR, 1'b1, 32'(i));
      rd(`CMPC_OFS_CSR, 32'(i + 32 + ((i == 0 || i == 3) ? 16 : 0)));
      apb(`CMPC_OFS_CSR, 1'b1, 32'(i + 16));
      pos_v <= 8'h10;
      settle;
      rd(`CMPC_OFS_CSR, 32'(i + ((i == 0 || i == 2) ? 16 : 0)));
    end
  endtask
  task t_irq;
    global_irq_enable <= 1'b1;
    apb(`CMPC_OFS_IRQ_STAT, 1'b1, 32'h1);
    apb(`CMPC_OFS_CSR, 1'b1, 32'h1B);
    pos_v <= 8'hF0;
    settle;
    chk({30'h0, comparator_irq_req, irq}, 32'h2);
    apb(`CMPC_OFS_IRQ_MASK, 1'b1, 32'h1);
    irq_vector_taken <= 1'b1;
    @(posedge pclk);
    irq_vector_taken <= 1'b0;
    @(negedge pclk);
    chk({30'h0, comparator_irq_req, irq}, 32'h1);
    apb(`CMPC_OFS_IRQ_STAT, 1'b1, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(`CMPC_OFS_CSR, 1'b1, 32'h14);
    global_irq_enable <= 1'b0;
  endtask
  task t_route;
    settle;
    // The timer side must enable its own capture interrupt; only the route is seen here.
    chk({30'h0, capture_route_enable, capture_input}, 32'h3);
    apb(`CMPC_OFS_CSR, 1'b1, 32'h84);
    pos_v <= 8'h10;
    settle;
    chk({30'h0, comparator_power_off, capture_input}, 32'h2);
    rd(`CMPC_OFS_CSR, 32'hA4);
    pos_v <= 8'hF0;
    apb(`CMPC_OFS_CSR, 1'b1, 32'h40);
    settle;
    rd(`CMPC_OFS_CSR, 32'h50);
    chk(32'(bandgap_positive_select), 32'h1);
  endtask
  task t_mux_pins;
    {cmp_positive_pin_in, cmp_negative_pin_in} <= 2'h3;
    // Software is assumed to have released converter power reduction before this.
    apb(`CMPC_OFS_CTRL_B, 1'b1, 32'h40);
    apb(`CMPC_OFS_MUXSEL, 1'b1, 32'h5);
    apb(`CMPC_OFS_DIDR, 1'b1, 32'h1);
    @(negedge pclk);
    chk({28'h0, negative_from_mux, negative_channel}, 32'hD);
    chk({28'h0, positive_pin_buffer_off, cmp_positive_pin_read, cmp_negative_pin_read}, 32'h5);
    apb(`CMPC_OFS_CONVA, 1'b1, 32'h80);
    @(negedge pclk);
    chk(32'(negative_from_mux), 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_modes;
    t_irq;
    t_route;
    t_mux_pins;
    end_sim;
  end
endmodule
